// ---- inc/reset_clock_supervisor_map.vh ----
// Constants for the reset and clock supervisor: register map, field
// positions, timing figures and option encodings.
// Assumes a 20 MHz CPU clock and a byte-wide register port.
//
// Behaviour
// - Supply below threshold holds static reset.
// - Upper threshold releases, lower threshold asserts.
// - Supply-drop reset drives reset pin low.
// - Threshold level chosen by option, three levels.
// - Supply reset flag set by hardware, zero-write clears.
// - All sources drive pin low during delay.
// - Vector fetched from top of memory map.
// - Source delay, 4096-cycle wait, then vector fetch.
// - Vector fetch lasts exactly two cycles.
// - External reset caught without a running clock.
// - Recognised external reset drives pin minimum width.
// - Reset pin is input plus open-drain output.
// - Watchdog underflow drives pin, then runs sequence.
// - Oscillator source chosen by option among seven.
// - Crystal oscillators keep running during reset.
// - Clock guard enabled or disabled by option.
// - Filter blocks spikes, stops when source recovers.
// - Lost clock selects safe oscillator, returns automatically.
// - Safe selection sets flag, interrupt if enabled.
// - Wait leaves guard running; guard interrupt wakes.
// - Halt freezes register, disables guard; wake rules.
// - Flag cleared by read after recovery; zero if off.
// - Interrupt needs enable set and CPU mask clear.
`ifndef RESET_CLOCK_SUPERVISOR_MAP_VH
`define RESET_CLOCK_SUPERVISOR_MAP_VH

`define ADDR_STATUS      8'h25
`define BIT_SUPPLY_FLAG  4
`define BIT_IRQ_ENABLE   2
`define BIT_SAFE_FLAG    1
`define BIT_WDOG_FLAG    0

`define CLK_PERIOD_NS    50
`define RSTL_OUT_NS      20000
`define RSTL_OUT_CYC     ((`RSTL_OUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAB_CYC         4096
`define FETCH_CYC        2
`define RELEASE_GUARD    4
`define VECTOR_LO        16'hFFFE
`define VECTOR_HI        16'hFFFF

`define OSC_EXT_CLOCK    3'h0
`define OSC_XTAL_FIRST   3'h1
`define OSC_XTAL_LAST    3'h4
`define OSC_EXT_RC       3'h5
`define OSC_INT_RC       3'h6
`define LEVEL_MAX        2'h2

`endif

// ---- design/level_sync.v ----
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit changes slowly compared with the clock.
`default_nettype none

module level_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;

	// The first stage feeds only the second stage.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // level_sync

`default_nettype wire

// ---- design/reset_clock_supervisor.v ----
// Reset and clock supervisor: merges external, supply-drop and watchdog
// resets onto the open-drain reset pin, sequences the CPU out of reset,
// and guards the main clock with a spike filter and a safe oscillator.
// Assumes analog comparators and clock monitors deliver levels from
// outside the clock domain, and the CPU drives its mode lines on clk.
`default_nettype none
`include "reset_clock_supervisor_map.vh"

module reset_clock_supervisor #(
	parameter RSTL_OUT = `RSTL_OUT_CYC,
	parameter STAB     = `STAB_CYC,
	parameter GUARD    = `RELEASE_GUARD
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        rst_pin_in,
	output reg         rst_pin_out,
	output reg         rst_pin_oe,
	input  wire        vdd_above_upper,
	input  wire        vdd_above_lower,
	input  wire        watchdog_underflow,
	input  wire [1:0]  opt_supply_level,
	input  wire [2:0]  opt_osc_select,
	input  wire        opt_guard_enable,
	input  wire        main_clk_ok,
	input  wire        main_clk_spike,
	input  wire        wait_mode,
	input  wire        halt_mode,
	input  wire        cpu_irq_mask,
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata,
	output reg  [1:0]  supply_level_sel,
	output reg  [2:0]  oscillator_selector,
	output reg         osc_enable,
	output reg         filter_active,
	output reg         safe_osc_select,
	output reg         clock_guard_irq,
	output reg         wake_from_wait,
	output reg         cpu_reset_n,
	output reg         vector_fetch,
	output reg  [15:0] fetch_addr
);

	localparam [1:0] ST_HOLD  = 2'h0;
	localparam [1:0] ST_STAB  = 2'h1;
	localparam [1:0] ST_FETCH = 2'h2;
	localparam [1:0] ST_RUN   = 2'h3;

	localparam [31:0] HOLD_W    = RSTL_OUT - 1;
	localparam [31:0] STAB_W    = STAB - 1;
	localparam [31:0] FETCH_W   = `FETCH_CYC - 1;
	localparam [31:0] GUARD_W   = GUARD;
	localparam [12:0] HOLD_END  = HOLD_W[12:0];
	localparam [12:0] STAB_END  = STAB_W[12:0];
	localparam [12:0] FETCH_END = FETCH_W[12:0];
	localparam [12:0] GUARD_END = GUARD_W[12:0];

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [12:0] cnt_q;
	reg  [12:0] cnt_d;
	reg         ext_catch_q;
	reg         catch_block_q;
	reg         supply_low_q;
	reg         wdog_seen_q;
	reg         opt_guard_q;
	reg         supply_flag_q;
	reg         wdog_flag_q;
	reg         irq_enable_q;
	reg         safe_flag_q;
	reg         safe_prev_q;
	wire        ext_seen;
	wire        above_upper;
	wire        above_lower;
	wire        clk_ok;
	wire        clk_spike;
	wire        catch_n;
	wire        any_source;
	wire        guard_on;
	wire        safe_now;
	wire        safe_rise;
	wire        reg_hit;
	wire        reg_write;
	wire        reg_read;

	level_sync #(
		.WIDTH (4),
		.INIT  (4'h3)
	) u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.async_in ({ext_catch_q, vdd_above_upper, vdd_above_lower,
			main_clk_ok}),
		.sync_out ({ext_seen, above_upper, above_lower, clk_ok})
	);

	level_sync #(
		.WIDTH (1),
		.INIT  (1'b0)
	) u_sync_spike (
		.clk      (clk),
		.rstn     (rstn),
		.async_in (main_clk_spike),
		.sync_out (clk_spike)
	);

	// The pin reads back our own drive as a reset, so the catcher is
	// blinded while we pull low and for a few cycles after the release
	// while the weak pull-up recovers. A pin still low after that is a
	// long external pulse and restarts the hold.
	assign catch_n = rstn & (rst_pin_in | catch_block_q);

	// Catches a low pin with no clock edge needed, even in halt.
	always @(posedge clk or negedge catch_n) begin
		if (!catch_n) begin
			ext_catch_q <= 1'b1;
		end else if (state_q == ST_HOLD) begin
			ext_catch_q <= 1'b0;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			catch_block_q <= 1'b1;
		end else begin
			catch_block_q <= (state_d == ST_HOLD) ||
				((state_d == ST_STAB) && (cnt_d < GUARD_END));
		end
	end

	// Comparator pair with hysteresis: release needs the upper level,
	// assertion waits for the lower one.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			supply_low_q <= 1'b1;
		end else if (supply_low_q) begin
			supply_low_q <= ~above_upper;
		end else begin
			supply_low_q <= ~above_lower;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdog_seen_q <= 1'b0;
		end else if (watchdog_underflow) begin
			wdog_seen_q <= 1'b1;
		end else if (state_q != ST_HOLD) begin
			wdog_seen_q <= 1'b0;
		end
	end

	// The external pulse itself is the far side's to stretch to the
	// minimum input width; any caught edge is honoured here.
	assign any_source = supply_low_q | ext_seen |
		watchdog_underflow;

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q + 13'h0001;
		case (state_q)
		ST_HOLD: begin
			// Minimum output width runs from recognition, or from recovery
			// for a supply drop; the pin stays low until every source has gone.
			if (cnt_q >= HOLD_END) begin
				cnt_d = HOLD_END;
				if (!any_source) begin
					state_d = ST_STAB;
					cnt_d   = 13'h0000;
				end
			end
			if (supply_low_q) begin
				cnt_d = 13'h0000;
			end
		end
		ST_STAB: begin
			if (any_source) begin
				state_d = ST_HOLD;
				cnt_d   = 13'h0000;
			end else if (cnt_q == STAB_END) begin
				state_d = ST_FETCH;
				cnt_d   = 13'h0000;
			end
		end
		ST_FETCH: begin
			if (any_source) begin
				state_d = ST_HOLD;
				cnt_d   = 13'h0000;
			end else if (cnt_q == FETCH_END) begin
				state_d = ST_RUN;
				cnt_d   = 13'h0000;
			end
		end
		default: begin
			cnt_d = 13'h0000;
			if (any_source) begin
				state_d = ST_HOLD;
			end
		end
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_HOLD;
			cnt_q   <= 13'h0000;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_pin_out  <= 1'b0;
			rst_pin_oe   <= 1'b1;
			cpu_reset_n  <= 1'b0;
			vector_fetch <= 1'b0;
			fetch_addr   <= `VECTOR_LO;
		end else begin
			// Open drain: the output level is always low, only the
			// enable moves.
			rst_pin_out  <= 1'b0;
			rst_pin_oe   <= (state_d == ST_HOLD);
			cpu_reset_n  <= (state_d == ST_RUN);
			vector_fetch <= (state_d == ST_FETCH);
			if (state_d == ST_FETCH && cnt_d == 13'h0001) begin
				fetch_addr <= `VECTOR_HI;
			end else begin
				fetch_addr <= `VECTOR_LO;
			end
		end
	end

	// Options are static but only trusted once captured during the
	// hold, so a reset wake reloads them cleanly; a halt wake keeps them.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			supply_level_sel    <= 2'h0;
			oscillator_selector <= `OSC_EXT_CLOCK;
			opt_guard_q         <= 1'b0;
		end else if (state_q == ST_HOLD) begin
			if (opt_supply_level > `LEVEL_MAX) begin
				supply_level_sel <= `LEVEL_MAX;
			end else begin
				supply_level_sel <= opt_supply_level;
			end
			if (opt_osc_select > `OSC_INT_RC) begin
				oscillator_selector <= `OSC_INT_RC;
			end else begin
				oscillator_selector <= opt_osc_select;
			end
			opt_guard_q <= opt_guard_enable;
		end
	end

	// Crystals keep running through reset so start-up time is not lost;
	// the RC and external sources are gated while the pin is held.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_enable <= 1'b0;
		end else begin
			osc_enable <= (state_d != ST_HOLD) ||
				((oscillator_selector >= `OSC_XTAL_FIRST) &&
				(oscillator_selector <= `OSC_XTAL_LAST));
		end
	end

	assign guard_on  = opt_guard_q & ~halt_mode;
	assign safe_now  = guard_on & ~clk_ok;
	assign safe_rise = safe_now & ~safe_prev_q;

	// Wait mode does not enter these terms: the guard keeps running.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			safe_osc_select <= 1'b0;
			filter_active   <= 1'b0;
			safe_prev_q     <= 1'b0;
		end else begin
			safe_osc_select <= safe_now;
			filter_active   <= guard_on & clk_spike;
			safe_prev_q     <= safe_now;
		end
	end

	assign reg_hit   = (addr == `ADDR_STATUS);
	assign reg_write = wr & reg_hit & ~halt_mode;
	assign reg_read  = rd & reg_hit & ~halt_mode;

	// Reset flags: hardware sets, a zero written clears, set wins.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			supply_flag_q <= 1'b0;
			wdog_flag_q   <= 1'b0;
		end else begin
			if (supply_low_q) begin
				supply_flag_q <= 1'b1;
			end else if (reg_write && !wdata[`BIT_SUPPLY_FLAG]) begin
				supply_flag_q <= 1'b0;
			end
			if (supply_low_q) begin
				wdog_flag_q <= 1'b0;
			end else if (watchdog_underflow || wdog_seen_q) begin
				wdog_flag_q <= 1'b1;
			end else if (reg_write && !wdata[`BIT_WDOG_FLAG]) begin
				wdog_flag_q <= 1'b0;
			end
		end
	end

	// Guard bits restart from reset values on any reset hold and stay
	// frozen through halt.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_enable_q <= 1'b0;
			safe_flag_q  <= 1'b0;
		end else if (state_q == ST_HOLD) begin
			irq_enable_q <= 1'b0;
			safe_flag_q  <= 1'b0;
		end else if (!halt_mode) begin
			if (reg_write) begin
				irq_enable_q <= wdata[`BIT_IRQ_ENABLE];
			end
			if (safe_rise) begin
				safe_flag_q <= 1'b1;
			end else if (reg_read && clk_ok && !safe_now) begin
				safe_flag_q <= 1'b0;
			end
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd && reg_hit) begin
			rdata <= {3'h0, supply_flag_q, 1'b0, irq_enable_q,
				safe_flag_q & opt_guard_q, wdog_flag_q};
		end else begin
			rdata <= 8'h00;
		end
	end

	// The interrupt only counts with the guard enabled by option; the
	// enable bit alone has no effect otherwise.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clock_guard_irq <= 1'b0;
			wake_from_wait  <= 1'b0;
		end else begin
			clock_guard_irq <= opt_guard_q & safe_flag_q &
				irq_enable_q & ~cpu_irq_mask;
			wake_from_wait  <= wait_mode & opt_guard_q &
				safe_flag_q & irq_enable_q;
		end
	end

endmodule // reset_clock_supervisor

`default_nettype wire

// ---- test/reset_clock_supervisor_sva.sv ----
// Port assertions for the reset and clock supervisor.
// Assumes a bind to the top module: one clock, asynchronous low reset.
`default_nettype none

module rcs_checker #(
	parameter RSTL_OUT = 4,
	parameter STAB     = 16
) (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        rst_pin_out,
	input wire logic        rst_pin_oe,
	input wire logic        vdd_above_lower,
	input wire logic        watchdog_underflow,
	input wire logic        opt_guard_enable,
	input wire logic        main_clk_ok,
	input wire logic        halt_mode,
	input wire logic        cpu_irq_mask,
	input wire logic        safe_osc_select,
	input wire logic        clock_guard_irq,
	input wire logic        cpu_reset_n,
	input wire logic        vector_fetch,
	input wire logic [15:0] fetch_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Length of the current pin-low stretch, so long widths need no
	// unrolled repetition.
	int unsigned low_n;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			low_n <= 0;
		else
			low_n <= rst_pin_oe ? low_n + 1 : 0;
	end

	a_pin_od: assert property (rst_pin_oe |-> !rst_pin_out)
		else $error("reset pin driven high");
	a_wdog_entry: assert property ((watchdog_underflow && cpu_reset_n)
		|=> rst_pin_oe && !cpu_reset_n)
		else $error("underflow did not pull the pin");
	a_out_width: assert property ($fell(rst_pin_oe) |->
		low_n >= RSTL_OUT)
		else $error("pin low pulse too short");
	a_stab_wait: assert property ($rose(vector_fetch) |->
		$past(rst_pin_oe, STAB + 1) && !$past(rst_pin_oe, STAB))
		else $error("stabilisation wait length wrong");
	a_fetch_two: assert property ($rose(vector_fetch) |->
		##1 vector_fetch ##1 (!vector_fetch && cpu_reset_n))
		else $error("fetch phase not two cycles");
	a_fetch_addr: assert property ($rose(vector_fetch) |->
		fetch_addr == 16'hFFFE ##1 fetch_addr == 16'hFFFF)
		else $error("fetch address wrong");
	a_pin_holds_cpu: assert property (rst_pin_oe |-> !cpu_reset_n)
		else $error("cpu runs while pin low");
	a_supply_hold: assert property (!vdd_above_lower [*5] |=> rst_pin_oe)
		else $error("supply drop not held in reset");
	a_guard_off: assert property (!opt_guard_enable |-> !safe_osc_select)
		else $error("safe clock with guard off");
	a_safe_select: assert property ((cpu_reset_n && opt_guard_enable
		&& !halt_mode && !main_clk_ok) [*4] |-> safe_osc_select)
		else $error("safe clock not selected");
	a_irq_mask: assert property (clock_guard_irq |-> !$past(cpu_irq_mask))
		else $error("interrupt while masked");

	c_fetch: cover property ($rose(vector_fetch));
	c_safe: cover property ($rose(safe_osc_select));
	c_irq: cover property ($rose(clock_guard_irq));
endmodule // rcs_checker

`default_nettype wire

// ---- test/reset_line_model.sv ----
// Board side of the reset line: weak pull-up plus an outside source.
// Assumes the device pulls the line through an open-drain enable.
`default_nettype none

module reset_line_model (
	input  wire logic clk,
	input  wire logic dev_oe,
	input  wire logic dev_out,
	output wire logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ext_low = 1'b0;

	// Any driver pulling low wins, else the pull-up gives a one.
	assign pin = !((dev_oe && !dev_out) || ext_low);

	// Whole cycles only, so the pulse never falls under the minimum.
	task pulse(input int n);
		ext_low <= 1'b1;
		repeat (n) @(posedge clk);
		ext_low <= 1'b0;
	endtask
endmodule // reset_line_model

`default_nettype wire

// ---- test/reset_clock_supervisor_bench.sv ----
// Self-checking bench for the reset and clock supervisor.
// Assumes the map header on the include path; checker and line model
// compiled before this file.
`default_nettype none
`include "reset_clock_supervisor_map.vh"

module reset_clock_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RSTL = 4;
	localparam int STAB = 16;
	typedef struct {logic [7:0] a, d, e;} row_t;
	// Write then read back; 8'h26 is unmapped.
	row_t rows [5] = '{'{8'h25, 8'h00, 8'h00}, '{8'h25, 8'h04, 8'h04},
		'{8'h25, 8'hFF, 8'h04}, '{8'h26, 8'hFF, 8'h00},
		'{8'h25, 8'h00, 8'h00}};
	logic clk = 0, rstn = 0, vdd_above_upper = 1, vdd_above_lower = 1;
	logic watchdog_underflow = 0, opt_guard_enable = 1, main_clk_ok = 1;
	logic main_clk_spike = 0, wait_mode = 0, halt_mode = 0;
	logic cpu_irq_mask = 1, wr = 0, rd = 0;
	logic [1:0]  opt_supply_level = 2'h3;
	logic [2:0]  opt_osc_select = 3'h2;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, got;
	wire logic   rst_pin_in, rst_pin_out, rst_pin_oe, osc_enable;
	wire logic   filter_active, safe_osc_select, clock_guard_irq;
	wire logic   wake_from_wait, cpu_reset_n, vector_fetch;
	wire logic [7:0]  rdata;
	wire logic [1:0]  supply_level_sel;
	wire logic [2:0]  oscillator_selector;
	wire logic [15:0] fetch_addr;
	int n_fail = 0, comparisons = 0, cyc = 0;

	always #25 clk = ~clk;

	reset_line_model LINE (.clk, .dev_oe(rst_pin_oe),
		.dev_out(rst_pin_out), .pin(rst_pin_in));

	reset_clock_supervisor #(.RSTL_OUT(RSTL), .STAB(STAB)) DUT (.clk,
		.rstn, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .vdd_above_upper,
		.vdd_above_lower, .watchdog_underflow, .opt_supply_level,
		.opt_osc_select, .opt_guard_enable, .main_clk_ok, .main_clk_spike,
		.wait_mode, .halt_mode, .cpu_irq_mask, .addr, .wdata, .wr, .rd,
		.rdata, .supply_level_sel, .oscillator_selector, .osc_enable,
		.filter_active, .safe_osc_select, .clock_guard_irq,
		.wake_from_wait, .cpu_reset_n, .vector_fetch, .fetch_addr);

	task test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task rreg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(posedge clk);
		d = rdata;
	endtask

	task wait_oe(input logic v, input int lim, output int n);
		n = 0;
		while (rst_pin_oe !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (rst_pin_oe !== v) begin
			n_fail++;
			$display("Error %0t: reset pin wait ran out", $time);
		end
	endtask

	task run_seq;
		int n;
		wait_oe(1'b1, 10, n);
		wait_oe(1'b0, 2000, n);
		n = 0;
		while (vector_fetch !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(n, STAB);
		chk(fetch_addr, `VECTOR_LO);
		@(posedge clk);
		chk({vector_fetch, fetch_addr}, {1'b1, `VECTOR_HI});
		@(posedge clk);
		chk({vector_fetch, cpu_reset_n}, 2'b01);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		chk({rst_pin_oe, cpu_reset_n}, 2'b10);
		rstn <= 1;
		run_seq();
		chk(oscillator_selector, 3'h2);
		chk(supply_level_sel, 2'h2);
		foreach (rows[i]) begin
			wreg(rows[i].a, rows[i].d);
			rreg(rows[i].a, got);
			chk(got, rows[i].e);
		end
		watchdog_underflow <= 1;
		@(posedge clk);
		watchdog_underflow <= 0;
		@(posedge clk);
		chk({rst_pin_oe, cpu_reset_n}, 2'b10);
		chk({osc_enable, rst_pin_in}, 2'b10);
		run_seq();
		rreg(8'h25, got);
		chk(got & 8'h11, 8'h01);
		opt_osc_select <= 3'h7;
		opt_supply_level <= 2'h1;
		vdd_above_lower <= 0;
		vdd_above_upper <= 0;
		repeat (8) @(posedge clk);
		chk({rst_pin_oe, rst_pin_in}, 2'b10);
		vdd_above_lower <= 1;
		repeat (12) @(posedge clk);
		chk(rst_pin_oe, 1);
		vdd_above_upper <= 1;
		run_seq();
		chk(oscillator_selector, 3'h6);
		chk(supply_level_sel, 2'h1);
		rreg(8'h25, got);
		chk(got & 8'h11, 8'h10);
		LINE.pulse(3);
		run_seq();
		// A one in the supply flag position keeps that flag set.
		wreg(8'h25, 8'h14);
		cpu_irq_mask <= 0;
		wait_mode <= 1;
		main_clk_ok <= 0;
		main_clk_spike <= 1;
		repeat (5) @(posedge clk);
		chk({safe_osc_select, filter_active}, 2'b11);
		chk({clock_guard_irq, wake_from_wait}, 2'b11);
		rreg(8'h25, got);
		chk(got, 8'h16);
		cpu_irq_mask <= 1;
		repeat (3) @(posedge clk);
		chk(clock_guard_irq, 0);
		halt_mode <= 1;
		wreg(8'h25, 8'h00);
		rreg(8'h25, got);
		chk(got, 8'h16);
		halt_mode <= 0;
		main_clk_ok <= 1;
		main_clk_spike <= 0;
		repeat (5) @(posedge clk);
		chk({safe_osc_select, filter_active}, 2'b00);
		rreg(8'h25, got);
		chk(got, 8'h16);
		rreg(8'h25, got);
		chk(got, 8'h14);
		opt_guard_enable <= 0;
		LINE.pulse(3);
		run_seq();
		main_clk_ok <= 0;
		repeat (5) @(posedge clk);
		chk({safe_osc_select, filter_active}, 2'b00);
		rreg(8'h25, got);
		chk(got, 8'h10);
		test_done();
	end
endmodule // reset_clock_supervisor_bench

bind reset_clock_supervisor rcs_checker #(.RSTL_OUT(RSTL_OUT),
	.STAB(STAB)) CHK (.clk, .rstn, .rst_pin_out, .rst_pin_oe,
	.vdd_above_lower, .watchdog_underflow, .opt_guard_enable,
	.main_clk_ok, .halt_mode, .cpu_irq_mask, .safe_osc_select,
	.clock_guard_irq, .cpu_reset_n, .vector_fetch, .fetch_addr);

`default_nettype wire
